// ### rtl/upper_interrupt_pin_mapper.v
// upper event-to-pin mapping registers and interrupt pin drive
`timescale 1ns/1ps
`default_nettype none
`include "irq_map_regs.vh"

module upper_interrupt_pin_mapper (
	input wire ref_clk,
	input wire nrst,
	// register access from the serial control port
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire [7:0] reg_wdata,
	input wire reg_rd,
	output reg [7:0] reg_rdata_q,
	output reg reg_rd_ack_q,
	// event sources, same clock
	input wire fuse_fault,
	input wire user_reg_fault,
	input wire keepalive_expire,
	input wire aux_activity,
	input wire aux_inactivity,
	input wire double_tap,
	input wire single_tap,
	// pin requests already merged from the lower mapping
	input wire lower_irq_a,
	input wire lower_irq_b,
	// results
	output reg keepalive_status_q,
	output reg irq_pin_a_q,
	output reg irq_pin_b_q
);

	////////////////////////////////////////////////////////////////////////
	// map registers

	reg [7:0] pin_one_upper_event_map_q;
	reg [7:0] pin_one_upper_event_map_d;
	reg [7:0] pin_two_upper_event_map_q;
	reg [7:0] pin_two_upper_event_map_d;
	wire wr_map_one;
	wire wr_map_two;

	assign wr_map_one = reg_wr && (reg_addr == `PIN_ONE_UPPER_MAP_ADDR);
	assign wr_map_two = reg_wr && (reg_addr == `PIN_TWO_UPPER_MAP_ADDR);

	always @*
	begin
		pin_one_upper_event_map_d = pin_one_upper_event_map_q;
		pin_two_upper_event_map_d = pin_two_upper_event_map_q;
		// reserved bit 5 never stores a one
		if (wr_map_one)
		begin
			pin_one_upper_event_map_d = reg_wdata & `UPPER_MAP_WR_MASK;
		end
		if (wr_map_two)
		begin
			pin_two_upper_event_map_d = reg_wdata & `UPPER_MAP_WR_MASK;
		end
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_one_upper_event_map_q <= `UPPER_MAP_RESET;
			pin_two_upper_event_map_q <= `UPPER_MAP_RESET;
		end
		else
		begin
			pin_one_upper_event_map_q <= pin_one_upper_event_map_d;
			pin_two_upper_event_map_q <= pin_two_upper_event_map_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// named enable fields of the two map registers

	wire pin_a_fuse_fault_en;
	wire pin_a_user_reg_fault_en;
	wire pin_a_keepalive_en;
	wire pin_a_aux_activity_en;
	wire pin_a_aux_inactivity_en;
	wire pin_a_double_tap_en;
	wire pin_a_single_tap_en;
	wire pin_b_fuse_fault_en;
	wire pin_b_user_reg_fault_en;
	wire pin_b_keepalive_en;
	wire pin_b_aux_activity_en;
	wire pin_b_aux_inactivity_en;
	wire pin_b_double_tap_en;
	wire pin_b_single_tap_en;
	reg [7:0] pin_a_enables;
	reg [7:0] pin_b_enables;

	// pin a fields
	assign pin_a_fuse_fault_en =
		pin_one_upper_event_map_q[`MAP_FUSE_FAULT_BIT];
	assign pin_a_user_reg_fault_en =
		pin_one_upper_event_map_q[`MAP_USER_REG_FAULT_BIT];
	assign pin_a_keepalive_en =
		pin_one_upper_event_map_q[`MAP_KEEPALIVE_BIT];
	assign pin_a_aux_activity_en =
		pin_one_upper_event_map_q[`MAP_AUX_ACTIVITY_BIT];
	assign pin_a_aux_inactivity_en =
		pin_one_upper_event_map_q[`MAP_AUX_INACTIVITY_BIT];
	assign pin_a_double_tap_en =
		pin_one_upper_event_map_q[`MAP_DOUBLE_TAP_BIT];
	assign pin_a_single_tap_en =
		pin_one_upper_event_map_q[`MAP_SINGLE_TAP_BIT];

	// pin b fields; bit 4 goes to pin b, as its field name says
	assign pin_b_fuse_fault_en =
		pin_two_upper_event_map_q[`MAP_FUSE_FAULT_BIT];
	assign pin_b_user_reg_fault_en =
		pin_two_upper_event_map_q[`MAP_USER_REG_FAULT_BIT];
	assign pin_b_keepalive_en =
		pin_two_upper_event_map_q[`MAP_KEEPALIVE_BIT];
	assign pin_b_aux_activity_en =
		pin_two_upper_event_map_q[`MAP_AUX_ACTIVITY_BIT];
	assign pin_b_aux_inactivity_en =
		pin_two_upper_event_map_q[`MAP_AUX_INACTIVITY_BIT];
	assign pin_b_double_tap_en =
		pin_two_upper_event_map_q[`MAP_DOUBLE_TAP_BIT];
	assign pin_b_single_tap_en =
		pin_two_upper_event_map_q[`MAP_SINGLE_TAP_BIT];

	// reserved position rebuilt as zero, whatever the register holds
	always @*
	begin
		pin_a_enables = 8'h00;
		pin_a_enables[`MAP_FUSE_FAULT_BIT] = pin_a_fuse_fault_en;
		pin_a_enables[`MAP_USER_REG_FAULT_BIT] = pin_a_user_reg_fault_en;
		pin_a_enables[`MAP_KEEPALIVE_BIT] = pin_a_keepalive_en;
		pin_a_enables[`MAP_AUX_ACTIVITY_BIT] = pin_a_aux_activity_en;
		pin_a_enables[`MAP_AUX_INACTIVITY_BIT] = pin_a_aux_inactivity_en;
		pin_a_enables[`MAP_DOUBLE_TAP_BIT] = pin_a_double_tap_en;
		pin_a_enables[`MAP_SINGLE_TAP_BIT] = pin_a_single_tap_en;
	end

	always @*
	begin
		pin_b_enables = 8'h00;
		pin_b_enables[`MAP_FUSE_FAULT_BIT] = pin_b_fuse_fault_en;
		pin_b_enables[`MAP_USER_REG_FAULT_BIT] = pin_b_user_reg_fault_en;
		pin_b_enables[`MAP_KEEPALIVE_BIT] = pin_b_keepalive_en;
		pin_b_enables[`MAP_AUX_ACTIVITY_BIT] = pin_b_aux_activity_en;
		pin_b_enables[`MAP_AUX_INACTIVITY_BIT] = pin_b_aux_inactivity_en;
		pin_b_enables[`MAP_DOUBLE_TAP_BIT] = pin_b_double_tap_en;
		pin_b_enables[`MAP_SINGLE_TAP_BIT] = pin_b_single_tap_en;
	end

	////////////////////////////////////////////////////////////////////////
	// keep-alive status flag

	reg keepalive_status_d;
	wire rd_status;

	// same strobe and address decode as the read path below
	assign rd_status = reg_rd && (reg_addr == `SECOND_STATUS_ADDR);

	// a new expiry in the clearing read cycle survives the clear
	// only a status read or reset clears the flag; an unread expiry holds the pin
	always @*
	begin
		keepalive_status_d = keepalive_status_q;
		if (rd_status)
		begin
			keepalive_status_d = 1'b0;
		end
		if (keepalive_expire)
		begin
			keepalive_status_d = 1'b1;
		end
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			keepalive_status_q <= 1'b0;
		end
		else
		begin
			keepalive_status_q <= keepalive_status_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read path

	reg [7:0] reg_rdata_d;
	reg [7:0] status_view;

	always @*
	begin
		status_view = 8'h00;
		status_view[`STATUS_KEEPALIVE_BIT] = keepalive_status_q;
	end

	// unmapped addresses read zero; read data shows the value before
	// any write in the same cycle
	always @*
	begin
		reg_rdata_d = reg_rdata_q;
		if (reg_rd)
		begin
			case (reg_addr)
				`PIN_ONE_UPPER_MAP_ADDR:
				begin
					reg_rdata_d = pin_one_upper_event_map_q;
				end
				`PIN_TWO_UPPER_MAP_ADDR:
				begin
					reg_rdata_d = pin_two_upper_event_map_q;
				end
				`SECOND_STATUS_ADDR:
				begin
					reg_rdata_d = status_view;
				end
				default:
				begin
					reg_rdata_d = 8'h00;
				end
			endcase
		end
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			reg_rdata_q <= `RDATA_RESET;
			reg_rd_ack_q <= 1'b0;
		end
		else
		begin
			reg_rdata_q <= reg_rdata_d;
			reg_rd_ack_q <= reg_rd;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// event vector in map bit order

	reg [7:0] event_vec;

	always @*
	begin
		event_vec = 8'h00;
		event_vec[`MAP_FUSE_FAULT_BIT] = fuse_fault;
		event_vec[`MAP_USER_REG_FAULT_BIT] = user_reg_fault;
		event_vec[`MAP_RESERVED_BIT] = 1'b0;
		// the sticky flag, not the raw pulse, is what reaches a pin
		event_vec[`MAP_KEEPALIVE_BIT] = keepalive_status_q;
		event_vec[`MAP_AUX_ACTIVITY_BIT] = aux_activity;
		event_vec[`MAP_AUX_INACTIVITY_BIT] = aux_inactivity;
		event_vec[`MAP_DOUBLE_TAP_BIT] = double_tap;
		event_vec[`MAP_SINGLE_TAP_BIT] = single_tap;
	end

	////////////////////////////////////////////////////////////////////////
	// per-pin gating

	wire hit_a;
	wire hit_b;

	pin_event_mapper map_a (
		.event_map(pin_a_enables),
		.event_vec(event_vec),
		.lower_hit(lower_irq_a),
		.pin_hit(hit_a)
	);

	pin_event_mapper map_b (
		.event_map(pin_b_enables),
		.event_vec(event_vec),
		.lower_hit(lower_irq_b),
		.pin_hit(hit_b)
	);

	////////////////////////////////////////////////////////////////////////
	// pin drive, registered so the pins never glitch on event edges
	// lower requests share the flop, so they and the direct events see one cycle of lag; keep-alive expiry sees two, via its sticky flag

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			irq_pin_a_q <= 1'b0;
			irq_pin_b_q <= 1'b0;
		end
		else
		begin
			irq_pin_a_q <= hit_a;
			irq_pin_b_q <= hit_b;
		end
	end

endmodule

`default_nettype wire

// ### rtl/irq_map_regs.vh
// constants for the upper interrupt pin mapper
//
// Behaviour
// - pin_one map bit 7 routes fuse fault to pin a; 0 blocks it.
// - pin_one map bit 6 routes user register fault to pin a.
// - bit 4 of each map routes keep-alive expiry to that map's pin.
// - pin_one map bit 3 routes aux channel activity to pin a.
// - pin_one map bit 2 routes aux channel inactivity to pin a.
// - pin_one map bit 1 routes double tap to pin a.
// - pin_one map bit 0 routes single tap to pin a.
// - pin_two map bit 7 routes fuse fault to pin b.
// - pin_two map bit 6 routes user register fault to pin b.
// - pin_two map bit 3 routes aux channel activity to pin b.
// - pin_two map bit 2 routes aux channel inactivity to pin b.
// - pin_two map bit 1 routes double tap to pin b.
// - pin_two map bit 0 routes single tap to pin b.
// - both maps reset to zero; bit 5 is read-only and reads zero.
// - keep-alive expiry sets status bit 4; reading that status clears it.
`ifndef IRQ_MAP_REGS_VH
`define IRQ_MAP_REGS_VH

// register addresses
`define PIN_ONE_UPPER_MAP_ADDR 8'h3a
`define PIN_TWO_UPPER_MAP_ADDR 8'h3b
`define SECOND_STATUS_ADDR 8'h0c

// reset values
`define UPPER_MAP_RESET 8'h00
`define RDATA_RESET 8'h00

// writable bits of a map register; bit 5 is reserved
`define UPPER_MAP_WR_MASK 8'hdf

// field positions inside a map register
`define MAP_FUSE_FAULT_BIT 7
`define MAP_USER_REG_FAULT_BIT 6
`define MAP_RESERVED_BIT 5
`define MAP_KEEPALIVE_BIT 4
`define MAP_AUX_ACTIVITY_BIT 3
`define MAP_AUX_INACTIVITY_BIT 2
`define MAP_DOUBLE_TAP_BIT 1
`define MAP_SINGLE_TAP_BIT 0

// keep-alive flag position in the second status register
`define STATUS_KEEPALIVE_BIT 4

`endif

// ### rtl/pin_event_mapper.v
// event gating and merge for one interrupt pin
`timescale 1ns/1ps
`default_nettype none
`include "irq_map_regs.vh"

module pin_event_mapper (
	input wire [7:0] event_map,
	input wire [7:0] event_vec,
	input wire lower_hit,
	output wire pin_hit
);

	////////////////////////////////////////////////////////////////////////
	wire [7:0] gated;

	// reserved position forced off even if a caller feeds it
	assign gated = event_map & event_vec & `UPPER_MAP_WR_MASK;
	assign pin_hit = (|gated) | lower_hit;

endmodule

`default_nettype wire

// ### sim/host_irq_watch.sv
// host model counting cycles with a pin raised
`timescale 1ns/1ps
`default_nettype none
module host_irq_watch (
	input wire logic ref_clk,
	input wire logic pin_a,
	input wire logic pin_b,
	output var int hits
);
	initial hits = 0;
	// level sampling only; the host never clears anything here
	always @(posedge ref_clk)
		hits <= hits + int'(pin_a | pin_b);
endmodule
`default_nettype wire

// ### sim/upper_interrupt_pin_mapper_properties.sv
// port assertions for the upper interrupt pin mapper
`timescale 1ns/1ps
`default_nettype none
module irq_map_chk (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata_q,
	input wire logic reg_rd_ack_q,
	input wire logic keepalive_expire,
	input wire logic lower_irq_a,
	input wire logic lower_irq_b,
	input wire logic keepalive_status_q,
	input wire logic irq_pin_a_q,
	input wire logic irq_pin_b_q
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire logic st = reg_rd && reg_addr == 8'h0c;
	AST_RD_ACK: assert property (reg_rd |=> reg_rd_ack_q)
		else $error("no ack");
	AST_NO_ACK: assert property (!reg_rd |=> !reg_rd_ack_q)
		else $error("stray ack");
	AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data moved");
	AST_RSVD: assert property (reg_rd_ack_q |-> !reg_rdata_q[5])
		else $error("bit 5 set");
	AST_KA_SET: assert property
		(keepalive_expire |=> keepalive_status_q) else $error("no flag");
	AST_KA_CLR: assert property
		(st && !keepalive_expire |=> !keepalive_status_q) else $error("no clr");
	AST_STAT: assert property
		(st |=> reg_rdata_q == {3'h0, $past(keepalive_status_q), 4'h0})
		else $error("bad status");
	AST_LOW_A: assert property (lower_irq_a |=> irq_pin_a_q)
		else $error("pin a low");
	AST_LOW_B: assert property (lower_irq_b |=> irq_pin_b_q)
		else $error("pin b low");
endmodule
bind upper_interrupt_pin_mapper irq_map_chk chk_u (.*);
`default_nettype wire

// ### sim/upper_interrupt_pin_mapper_tb.sv
// self-checking bench for the upper interrupt pin mapper
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin fails++; \
	$display("mismatch %0t got %h exp %h", $time, a, e); end end
module upper_interrupt_pin_mapper_tb;
	logic ref_clk = 0, nrst = 0, wr = 0, rd = 0, ka = 0, ack, kq, pa, pb;
	logic [7:0] addr = 8'h00, wd = 8'h00, ev = 8'h00, rdata;
	logic [1:0] low = 2'h0;
	logic [31:0] s = 32'h4a, r;
	int fails = 0, checks = 0, hits;
	always #20 ref_clk = ~ref_clk;
	upper_interrupt_pin_mapper dut_u (.ref_clk(ref_clk), .nrst(nrst),
		.reg_addr(addr), .reg_wr(wr), .reg_wdata(wd), .reg_rd(rd),
		.reg_rdata_q(rdata), .reg_rd_ack_q(ack), .fuse_fault(ev[7]),
		.user_reg_fault(ev[6]), .keepalive_expire(ka), .aux_activity(ev[3]),
		.aux_inactivity(ev[2]), .double_tap(ev[1]), .single_tap(ev[0]),
		.lower_irq_a(low[1]), .lower_irq_b(low[0]),
		.keepalive_status_q(kq), .irq_pin_a_q(pa), .irq_pin_b_q(pb));
	host_irq_watch host_u (.ref_clk(ref_clk), .pin_a(pa), .pin_b(pb),
		.hits(hits));
	function logic [31:0] rnd();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	// bit 4 of e stands for the sticky keep-alive flag
	function logic pin(logic [7:0] m, logic [7:0] e, logic l);
		return |(m & e & 8'hdf) | l;
	endfunction
	task cyc();
		@(posedge ref_clk);
		#1;
	endtask
	// extra idle edge keeps strobes from being re-driven in one step
	task acc(logic w, logic [7:0] a, logic [7:0] d);
		addr = a;
		wd = d;
		wr = w;
		rd = !w;
		cyc();
		wr = 0;
		rd = 0;
		`CHK(ack, !w)
		cyc();
		`CHK(ack, 1'b0)
	endtask
	task summarize();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		repeat (8) cyc();
		nrst = 1;
		acc(0, 8'h3b, 8'h00);
		`CHK(rdata, 8'h00)
		acc(1, 8'h3a, 8'hff);
		acc(0, 8'h3a, 8'h00);
		`CHK(rdata, 8'hdf)
		acc(0, 8'h7e, 8'h00);
		`CHK(rdata, 8'h00)
		repeat (60)
		begin
			r = rnd();
			acc(1, 8'h3a, r[7:0]);
			acc(1, 8'h3b, r[15:8]);
			acc(0, 8'h3b, 8'h00);
			`CHK(rdata, r[15:8] & 8'hdf)
			acc(0, 8'h3a, 8'h00);
			`CHK(rdata, r[7:0] & 8'hdf)
			ev = r[23:16];
			ka = r[20];
			low = r[25:24];
			cyc();
			ka = 0;
			cyc();
			`CHK(pa, pin(r[7:0], ev, low[1]))
			`CHK(pb, pin(r[15:8], ev, low[0]))
			`CHK(kq, r[20])
			acc(0, 8'h0c, 8'h00);
			`CHK(rdata, {3'h0, r[20], 4'h0})
			`CHK(kq, 1'b0)
		end
		`CHK(hits != 0, 1'b1)
		// set wins when expiry and status read share an edge
		addr = 8'h0c;
		rd = 1;
		ka = 1;
		cyc();
		rd = 0;
		ka = 0;
		`CHK(rdata, 8'h00)
		cyc();
		`CHK(kq, 1'b1)
		acc(0, 8'h0c, 8'h00);
		`CHK(rdata, 8'h10)
		// mid-run reset: maps back to zero, events alone reach no pin
		ev = 8'hff;
		low = 2'h0;
		nrst = 0;
		cyc();
		nrst = 1;
		cyc();
		`CHK({pa, pb, kq}, 3'h0)
		acc(0, 8'h3a, 8'h00);
		`CHK(rdata, 8'h00)
		acc(0, 8'h3b, 8'h00);
		`CHK(rdata, 8'h00)
		summarize();
	end
	initial
	begin
		#200000;
		fails++;
		summarize();
	end
endmodule
`default_nettype wire
